// *** hdl/irq_wdt_pkg.sv ***
/*
 package for the interrupt and watchdog unit: register offsets, field
 positions, reset values, watchdog timing and the carrier structs.
 assumes a 125 MHz hclk and word-aligned AHB-Lite register access.
*/
package irq_wdt_pkg;

   localparam logic [7:0]  FLAG_REG_OFS   = 8'h00;
   localparam logic [7:0]  ENAB_REG_OFS   = 8'h04;
   localparam logic [7:0]  PWRCTL_REG_OFS  = 8'h08;
   localparam logic [7:0]  PWRCTL2_REG_OFS = 8'h0c;
   localparam logic [7:0]  STAT_REG_OFS   = 8'h10;
   localparam logic [7:0]  PRESC_REG_OFS  = 8'h14;
   localparam logic [7:0]  PORT_REG_OFS   = 8'h18;
   localparam logic [7:0]  LVDS_REG_OFS   = 8'h1c;

   localparam int T0_BIT    = 0;
   localparam int CHG_BIT   = 1;
   localparam int EXT_BIT   = 2;
   localparam int T1_BIT    = 3;
   localparam int WDT_BIT   = 6;
   localparam int LVD_BIT   = 7;
   localparam int RUN_BIT   = 7;
   localparam int LVD_EN_BIT = 5;
   localparam int LVDST_BIT = 6;
   localparam int TO_BIT    = 4;
   localparam int PTW_BIT   = 3;
   localparam int EXTS_BIT  = 6;
   localparam int EDGE_BIT  = 7;

   localparam logic        WDT_RUN_RST = 1'b1;
   localparam logic        TO_N_RST    = 1'b1;
   localparam logic [11:0] TRAP_VECTOR = 12'h001;
   localparam logic [11:0] HW_VECTOR   = 12'h008;

   localparam real CLK_KHZ     = 125000.0;
   localparam real WDT_P0_MS   = 3.5;
   localparam real WDT_P1_MS   = 15.0;
   localparam real WDT_P2_MS   = 60.0;
   localparam real WDT_P3_MS   = 250.0;
   localparam int  WDT_P0_CYC  = int'(WDT_P0_MS * CLK_KHZ);
   localparam int  WDT_P1_CYC  = int'(WDT_P1_MS * CLK_KHZ);
   localparam int  WDT_P2_CYC  = int'(WDT_P2_MS * CLK_KHZ);
   localparam int  WDT_P3_CYC  = int'(WDT_P3_MS * CLK_KHZ);

   typedef struct packed {
      logic enable_irqs_instr;
      logic disable_irqs_instr;
      logic return_from_irq_instr;
      logic trap;
      logic watchdog_clear_instr;
   } core_ops_t;

   typedef struct packed {
      logic       enable;
      logic       irq_mode;
      logic [1:0] period;
   } wdt_cfg_t;

   typedef struct packed {
      logic        fetch;
      logic [11:0] addr;
   } vector_t;

endpackage : irq_wdt_pkg

// *** hdl/irq_wdt_unit.sv ***
/*
 interrupt controller, watchdog and low-voltage flag logic of a small mcu,
 with an AHB-Lite register slave. assumes core strobes and timer events
 are one-cycle pulses on hclk; pins and comparator may be asynchronous.
*/
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module irq_wdt_unit
   import irq_wdt_pkg::*;
#(
   parameter int WDT_CYC_0 = WDT_P0_CYC,
   parameter int WDT_CYC_1 = WDT_P1_CYC,
   parameter int WDT_CYC_2 = WDT_P2_CYC,
   parameter int WDT_CYC_3 = WDT_P3_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire wdt_cfg_t    wdt_cfg,
   input  wire core_ops_t   core_ops,
   input  wire logic        timer0_rollover,
   input  wire logic        timer1_wrap,
   input  wire logic [5:0]  port_pins,
   input  wire logic [5:0]  port_is_input,
   input  wire logic        lvd_compare,
   output logic [3:0]       lvd_level,
   output vector_t          vector,
   output logic             irq_request,
   output logic             wdt_reset
);

   typedef struct packed {
      logic [7:0]  flags;
      logic [7:0]  enables;
      logic        global_irq_enable;
      logic        wdt_run;
      logic        lvd_en;
      logic        to_n;
      logic        pre_to_wdt;
      logic [2:0]  pre_sel;
      logic [5:0]  chg_sel;
      logic        ext_sel;
      logic        edge_sel;
      logic [3:0]  lvd_sel;
      logic [5:0]  pin_s1;
      logic [5:0]  pin_s2;
      logic [5:0]  pin_prev;
      logic        lvd_s1;
      logic        lvd_s2;
      logic        lvd_prev;
      logic [24:0] wdt_cnt;
      logic [7:0]  pre_cnt;
      logic        ap_valid;
      logic        ap_write;
      logic [7:0]  ap_addr;
      logic [31:0] rdata;
      vector_t     vec;
      logic        wdt_rst;
   } state_t;

   state_t      state_ff;
   state_t      nxt_state;
   logic [7:0]  events;
   logic        lvd_out;
   logic        wdt_active;
   logic        period_done;
   logic        timeout;
   logic        wr;
   logic        hw_pending;
   logic [24:0] period_last;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] pre_last(input logic [2:0] sel,
                                           input logic       irq_mode);
      logic [8:0] ratio;
      ratio = irq_mode ? (9'h002 << sel) : (9'h001 << sel);
      return 8'(ratio - 9'h001);
   endfunction : pre_last

   function automatic logic [3:0] lvd_decode(input logic [3:0] sel);
      logic [3:0] lvl;
      lvl = 4'h0;
      casez (sel)
         4'b0???: lvl = {1'b0, sel[2:0]};
         4'b100?: lvl = 4'h8;
         4'b101?: lvl = 4'h9;
         default: lvl = 4'ha;
      endcase
      return lvl;
   endfunction : lvd_decode

   function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a,
                                            input logic lo);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         FLAG_REG_OFS:    d[7:0] = s.flags & s.enables;
         ENAB_REG_OFS:    d[7:0] = s.enables;
         PWRCTL_REG_OFS:  d[7:0] = {s.wdt_run, 1'b0, s.lvd_en, 5'h00};
         PWRCTL2_REG_OFS: d[LVDST_BIT] = lo;
         STAT_REG_OFS:  d[TO_BIT] = s.to_n;
         PRESC_REG_OFS: d[7:0] = {4'h0, s.pre_to_wdt, s.pre_sel};
         PORT_REG_OFS:  d[7:0] = {s.edge_sel, s.ext_sel, s.chg_sel};
         LVDS_REG_OFS:  d[3:0] = s.lvd_sel;
         default:       d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////
   // event detection

   always_comb
   begin
      case (wdt_cfg.period)
         2'd0:    period_last = 25'(WDT_CYC_0 - 1);
         2'd1:    period_last = 25'(WDT_CYC_1 - 1);
         2'd2:    period_last = 25'(WDT_CYC_2 - 1);
         default: period_last = 25'(WDT_CYC_3 - 1);
      endcase
   end

   assign lvd_out     = ~state_ff.lvd_en | state_ff.lvd_s2;
   assign wdt_active  = wdt_cfg.enable & state_ff.wdt_run;
   assign period_done = wdt_active & (state_ff.wdt_cnt == period_last);
   assign timeout     = period_done & (~state_ff.pre_to_wdt |
                        (state_ff.pre_cnt == pre_last(state_ff.pre_sel, wdt_cfg.irq_mode)));
   assign wr          = state_ff.ap_valid & state_ff.ap_write;
   assign hw_pending  = state_ff.global_irq_enable &
                        |(state_ff.flags & state_ff.enables);

   always_comb
   begin
      events          = 8'h00;
      events[T0_BIT]  = timer0_rollover;
      events[T1_BIT]  = timer1_wrap;
      events[WDT_BIT] = timeout & wdt_cfg.irq_mode;
      events[CHG_BIT] = |((state_ff.pin_s2 ^ state_ff.pin_prev) & state_ff.chg_sel &
                          port_is_input & {5'h1f, ~state_ff.ext_sel});
      events[EXT_BIT] = state_ff.ext_sel &
                        (state_ff.edge_sel ? (state_ff.pin_s2[0] & ~state_ff.pin_prev[0])
                                           : (~state_ff.pin_s2[0] & state_ff.pin_prev[0]));
      events[LVD_BIT] = state_ff.lvd_prev & ~lvd_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      nxt_state          = state_ff;
      nxt_state.pin_s1   = port_pins;
      nxt_state.pin_s2   = state_ff.pin_s1;
      nxt_state.pin_prev = state_ff.pin_s2;
      nxt_state.lvd_s1   = lvd_compare;
      nxt_state.lvd_s2   = state_ff.lvd_s1;
      nxt_state.lvd_prev = lvd_out;
      nxt_state.wdt_rst  = 1'b0;
      nxt_state.vec      = '0;

      // bus: address phase capture, read data registered for the data phase
      nxt_state.ap_valid = hsel & htrans[1] & hready;
      nxt_state.ap_write = hwrite;
      nxt_state.ap_addr  = haddr[7:0];
      nxt_state.rdata    = read_mux(state_ff, haddr[7:0], lvd_out);
      if (wr)
      begin
         case (state_ff.ap_addr)
            FLAG_REG_OFS:  nxt_state.flags = state_ff.flags & hwdata[7:0];
            ENAB_REG_OFS:  nxt_state.enables = hwdata[7:0];
            PWRCTL_REG_OFS:
            begin
               nxt_state.wdt_run = hwdata[RUN_BIT];
               nxt_state.lvd_en  = hwdata[LVD_EN_BIT];
            end
            PRESC_REG_OFS:
            begin
               nxt_state.pre_to_wdt = hwdata[PTW_BIT];
               nxt_state.pre_sel    = hwdata[2:0];
               if (hwdata[PTW_BIT] != state_ff.pre_to_wdt)
                  nxt_state.pre_cnt = 8'h00;
            end
            PORT_REG_OFS:
            begin
               nxt_state.chg_sel  = hwdata[5:0];
               nxt_state.ext_sel  = hwdata[EXTS_BIT];
               nxt_state.edge_sel = hwdata[EDGE_BIT];
            end
            LVDS_REG_OFS:  nxt_state.lvd_sel = hwdata[3:0];
            default:       nxt_state.flags = state_ff.flags;
         endcase
      end
      nxt_state.flags = nxt_state.flags | events;

      // watchdog
      if (wdt_active)
      begin
         nxt_state.wdt_cnt = period_done ? 25'h0 : 25'(state_ff.wdt_cnt + 25'h1);
         if (period_done && state_ff.pre_to_wdt)
            nxt_state.pre_cnt = timeout ? 8'h00 : 8'(state_ff.pre_cnt + 8'h01);
      end
      if (timeout)
      begin
         nxt_state.to_n    = 1'b0;
         nxt_state.wdt_rst = ~wdt_cfg.irq_mode;
      end
      if (core_ops.watchdog_clear_instr)
      begin
         nxt_state.wdt_cnt = 25'h0;
         if (state_ff.pre_to_wdt)
         begin
            nxt_state.pre_cnt = 8'h00;
            nxt_state.to_n    = 1'b1;
         end
      end

      // global enable and vectoring
      if (core_ops.enable_irqs_instr || core_ops.return_from_irq_instr)
         nxt_state.global_irq_enable = 1'b1;
      if (core_ops.disable_irqs_instr)
         nxt_state.global_irq_enable = 1'b0;
      if (core_ops.trap)
      begin
         nxt_state.vec.fetch         = 1'b1;
         nxt_state.vec.addr          = TRAP_VECTOR;
         nxt_state.global_irq_enable = 1'b0;
      end
      else if (hw_pending)
      begin
         nxt_state.vec.fetch         = 1'b1;
         nxt_state.vec.addr          = HW_VECTOR;
         nxt_state.global_irq_enable = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_ff         <= '0;
         state_ff.wdt_run <= WDT_RUN_RST;
         state_ff.to_n    <= TO_N_RST;
         state_ff.lvd_s1  <= 1'b1;
         state_ff.lvd_s2  <= 1'b1;
         state_ff.lvd_prev <= 1'b1;
      end
      else
         state_ff <= nxt_state;
   end

   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = state_ff.rdata;
   assign lvd_level   = lvd_decode(state_ff.lvd_sel);
   assign vector      = state_ff.vec;
   assign irq_request = hw_pending;
   assign wdt_reset   = state_ff.wdt_rst;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_trap_vec;
      @(posedge hclk) disable iff (!hresetn)
      core_ops.trap |=> vector.fetch && vector.addr == 12'h001
                        && !state_ff.global_irq_enable;
   endproperty
   a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

   property p_hw_vec;
      @(posedge hclk) disable iff (!hresetn)
      (hw_pending && !core_ops.trap) |=> vector.fetch && vector.addr == 12'h008
                                         && !state_ff.global_irq_enable;
   endproperty
   a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");

   property p_irq_return;
      @(posedge hclk) disable iff (!hresetn)
      (core_ops.return_from_irq_instr && !core_ops.disable_irqs_instr && !core_ops.trap
       && !hw_pending)
      |=> state_ff.global_irq_enable;
   endproperty
   a_irq_return: assert property (p_irq_return) else $error("return left enable clear");

   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      timer0_rollover |=> state_ff.flags[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("timer0 event lost");

   property p_flag_hold;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff.flags[3] && !(wr && state_ff.ap_addr == FLAG_REG_OFS))
      |=> state_ff.flags[3];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_timeout;
      @(posedge hclk) disable iff (!hresetn)
      (timeout && !core_ops.watchdog_clear_instr) |=> !state_ff.to_n
                                        && (wdt_reset == !wdt_cfg.irq_mode);
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout effect wrong");

   property p_wdt_clear;
      @(posedge hclk) disable iff (!hresetn)
      (core_ops.watchdog_clear_instr && state_ff.pre_to_wdt && !wr)
      |=> state_ff.wdt_cnt == 25'h0 && state_ff.pre_cnt == 8'h00 && state_ff.to_n;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear wrong");

   property p_lvd_flag;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff.lvd_en && $fell(state_ff.lvd_s2) && $stable(state_ff.lvd_en))
      |=> state_ff.flags[7];
   endproperty
   a_lvd_flag: assert property (p_lvd_flag) else $error("low voltage flag missed");

   property p_read_gate;
      @(posedge hclk) disable iff (!hresetn)
      (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == FLAG_REG_OFS)
      |=> hrdata[7:0] == ($past(state_ff.flags) & $past(state_ff.enables));
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("flag read not gated");

endmodule : irq_wdt_unit
`default_nettype wire

// *** sim/core_model.sv ***
/*
 partner model of the core sequencer: registers commanded ops, one cycle late, as core
 strobes and logs vector fetches. assumes the unit's hclk and hresetn.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model
   import irq_wdt_pkg::*;
(
   input  wire logic      hclk,
   input  wire logic      hresetn,
   input  wire vector_t   vector,
   input  wire core_ops_t op_cmd,
   output core_ops_t      core_ops,
   output logic [11:0]    last_vec,
   output logic [7:0]     n_fetch
);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         core_ops <= '0;
         last_vec <= '0;
         n_fetch  <= '0;
      end
      else
      begin
         core_ops <= op_cmd;
         // no return straight after a nesting enable
         if (core_ops.enable_irqs_instr)
         begin
            core_ops.return_from_irq_instr <= 1'b0;
         end
         if (vector.fetch)
         begin
            last_vec <= vector.addr;
            n_fetch  <= n_fetch + 8'h01;
         end
      end
   end
endmodule : core_model
`default_nettype wire

// *** sim/tb_interrupt_and_watchdog_unit.sv ***
/*
 self-checking bench of the interrupt and watchdog unit with a core model.
 assumes short watchdog counts 20/40/60/80 and a zero-wait bus slave.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_and_watchdog_unit
   import irq_wdt_pkg::*;
;
   localparam int CYC [4] = '{20, 40, 60, 80};
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wdt_cfg_t    wdt_cfg;
   core_ops_t   op_cmd, core_ops;
   logic        t0_ev, t1_ev, lvd_compare, irq_request, wdt_reset;
   logic [5:0]  pins, pin_in;
   logic [3:0]  lvd_level;
   vector_t     vector;
   logic [11:0] last_vec;
   logic [7:0]  n_fetch;
   int          miscompares, n_compared, cyc;

   irq_wdt_unit #(.WDT_CYC_0(20), .WDT_CYC_1(40), .WDT_CYC_2(60), .WDT_CYC_3(80)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_cfg(wdt_cfg),
      .core_ops(core_ops), .timer0_rollover(t0_ev), .timer1_wrap(t1_ev),
      .port_pins(pins), .port_is_input(pin_in), .lvd_compare(lvd_compare),
      .lvd_level(lvd_level), .vector(vector), .irq_request(irq_request),
      .wdt_reset(wdt_reset));
   core_model i_core (.hclk(hclk), .hresetn(hresetn), .vector(vector), .op_cmd(op_cmd),
      .core_ops(core_ops), .last_vec(last_vec), .n_fetch(n_fetch));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic ev);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      t0_ev  <= ev;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      t0_ev  <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, 1'b0);
      chk(nm, exp, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rdc

   task automatic op(input core_ops_t o);
      op_cmd <= o;
      @(posedge hclk);
      op_cmd <= '0;
      @(posedge hclk);
   endtask : op

   task automatic evt(input logic a, input logic b);
      t0_ev <= a;
      t1_ev <= b;
      @(posedge hclk);
      t0_ev <= 1'b0;
      t1_ev <= 1'b0;
      @(posedge hclk);
   endtask : evt

   task automatic fetch_chk(input logic [11:0] a, input logic exp);
      logic [7:0] n0;
      n0 = n_fetch;
      repeat (6) @(posedge hclk);
      chk("fetch count", {31'h0, exp}, {24'h0, n_fetch - n0});
      if (exp)
         chk("vector", {20'h0, a}, {20'h0, last_vec});
   endtask : fetch_chk

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc("run bit", PWRCTL_REG_OFS, 32'h80);
      rdc("status", STAT_REG_OFS, 32'h10);
      rdc("lvd state", PWRCTL2_REG_OFS, 32'h40);
      wr(8'h40, 32'hff);
      rdc("unmapped", 8'h40, 32'h0);
   endtask : t_reset

   task automatic t_flags;
      evt(1'b1, 1'b1);
      rdc("masked flags", FLAG_REG_OFS, 32'h0);
      wr(ENAB_REG_OFS, 32'h09);
      rdc("flags", FLAG_REG_OFS, 32'h09);
      chk("irq gated", 32'h0, {31'h0, irq_request});
      wr(FLAG_REG_OFS, 32'h08);
      rdc("flag clear", FLAG_REG_OFS, 32'h08);
      xfer(1'b1, FLAG_REG_OFS, 32'h0, 1'b1);
      rdc("clear vs event", FLAG_REG_OFS, 32'h01);
      wr(FLAG_REG_OFS, 32'h0);
   endtask : t_flags

   task automatic t_vectors;
      evt(1'b1, 1'b0);
      fetch_chk(HW_VECTOR, 1'b0);
      op('{enable_irqs_instr: 1'b1, default: 1'b0});
      fetch_chk(HW_VECTOR, 1'b1);
      chk("enable cleared", 32'h0, {31'h0, irq_request});
      op('{return_from_irq_instr: 1'b1, default: 1'b0});
      fetch_chk(HW_VECTOR, 1'b1);
      wr(FLAG_REG_OFS, 32'h0);
      op('{enable_irqs_instr: 1'b1, default: 1'b0});
      op('{disable_irqs_instr: 1'b1, default: 1'b0});
      evt(1'b1, 1'b0);
      fetch_chk(HW_VECTOR, 1'b0);
      op('{trap: 1'b1, default: 1'b0});
      fetch_chk(TRAP_VECTOR, 1'b1);
      wr(FLAG_REG_OFS, 32'h0);
      op('{enable_irqs_instr: 1'b1, default: 1'b0});
      op('{trap: 1'b1, default: 1'b0});
      fetch_chk(TRAP_VECTOR, 1'b1);
      evt(1'b1, 1'b0);
      fetch_chk(HW_VECTOR, 1'b0);
      wr(FLAG_REG_OFS, 32'h0);
   endtask : t_vectors

   task automatic t_wdt;
      int n;
      int exp;
      wdt_cfg <= '{enable: 1'b1, irq_mode: 1'b1, period: 2'd0};
      wr(ENAB_REG_OFS, 32'h49);
      wr(PWRCTL_REG_OFS, 32'h0);
      op('{watchdog_clear_instr: 1'b1, default: 1'b0});
      repeat (100) @(posedge hclk);
      rdc("stopped wdt", FLAG_REG_OFS, 32'h0);
      wr(PWRCTL_REG_OFS, 32'h80);
      repeat (60) @(posedge hclk);
      rdc("wdt flag", FLAG_REG_OFS, 32'h40);
      rdc("timeout status", STAT_REG_OFS, 32'h0);
      wr(PRESC_REG_OFS, 32'h08);
      op('{watchdog_clear_instr: 1'b1, default: 1'b0});
      rdc("status set", STAT_REG_OFS, 32'h10);
      wdt_cfg.irq_mode <= 1'b0;
      for (int p = 0; p < 4; p++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            wdt_cfg.period <= 2'(p);
            wr(PRESC_REG_OFS, 32'h08 | 32'(s));
            op('{watchdog_clear_instr: 1'b1, default: 1'b0});
            n = 0;
            while (wdt_reset !== 1'b1 && n < 1000)
            begin
               @(posedge hclk);
               n++;
            end
            exp = CYC[p] << s;
            chk("wdt period", exp, (n >= exp - 3 && n <= exp + 4) ? exp : n);
         end
      end
      wdt_cfg.enable <= 1'b0;
      wr(FLAG_REG_OFS, 32'h0);
   endtask : t_wdt

   task automatic t_lvd;
      wr(PWRCTL_REG_OFS, 32'h20);
      wr(ENAB_REG_OFS, 32'h80);
      lvd_compare <= 1'b0;
      repeat (8) @(posedge hclk);
      rdc("lvd state", PWRCTL2_REG_OFS, 32'h0);
      rdc("lvd flag", FLAG_REG_OFS, 32'h80);
      lvd_compare <= 1'b1;
      wr(FLAG_REG_OFS, 32'h0);
      for (int c = 0; c < 16; c++)
      begin
         wr(LVDS_REG_OFS, 32'(c));
         repeat (2) @(posedge hclk);
         chk("lvd level", (c < 8) ? c : (c < 10) ? 8 : (c < 12) ? 9 : 10, 32'(lvd_level));
      end
   endtask : t_lvd

   task automatic t_port;
      wr(ENAB_REG_OFS, 32'h06);
      wr(PORT_REG_OFS, 32'h3f);
      pins <= 6'h08;
      repeat (8) @(posedge hclk);
      rdc("change flag", FLAG_REG_OFS, 32'h02);
      wr(FLAG_REG_OFS, 32'h0);
      pin_in <= 6'h37;
      pins   <= 6'h00;
      repeat (8) @(posedge hclk);
      pins   <= 6'h08;
      repeat (8) @(posedge hclk);
      rdc("output pin change", FLAG_REG_OFS, 32'h0);
      pin_in <= 6'h3f;
      wr(PORT_REG_OFS, 32'hff);
      pins <= 6'h09;
      repeat (8) @(posedge hclk);
      rdc("rising edge", FLAG_REG_OFS, 32'h04);
      wr(FLAG_REG_OFS, 32'h0);
      wr(PORT_REG_OFS, 32'h7f);
      pins <= 6'h08;
      repeat (8) @(posedge hclk);
      rdc("falling edge", FLAG_REG_OFS, 32'h04);
   endtask : t_port

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         results();
      end
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      wdt_cfg = '0;
      op_cmd = '0;
      t0_ev = 1'b0;
      t1_ev = 1'b0;
      pins = 6'h00;
      pin_in = 6'h3f;
      lvd_compare = 1'b1;
      cyc = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_flags();
      t_vectors();
      t_wdt();
      t_lvd();
      t_port();
      results();
   end
endmodule : tb_interrupt_and_watchdog_unit
`default_nettype wire
